// File: core/bss_top.sv
// start-up, shutdown and gate interlock sequencer with AXI4-Lite status port
// What this block does
// (R1) disable pin low: oscillator off, gates low, re-arm
// (R2) disabled: error amp off, only pull-up on
// (R3) pin back above trip: full new initialisation
// (R4) supply good rising starts setpoint sample phase
// (R5) pin held low at power-up postpones initialisation
// (R6) sequence timer waits for pin above trip
// (R7) fixed delay before setpoint sampling begins
// (R8) delay: low-side driver off, setpoint source on
// (R9) sampling lasts zero up to maximum time
// (R10) setpoint held digitally until supply lost or pin back above trip
// (R11) after sampling, short init then soft-start
// (R12) low-side pin senses setpoint only after reset/release
// (R13) trip: two dummy soft-starts, then retry
// (R14) overcurrent: switch-node drop against stored setpoint
// (R15) low-side on only after high-side off seen
// (R16) high-side on only after low-side off seen
// (R17) soft-start reference in 64 equal steps
// (R18) overcurrent window opens after blanking, ends with drive
// (R19) all timing counted on clock, cleared on reset
`timescale 1ns/100ps
`default_nettype none

module bss_top
	import bss_pkg::*;
#(
	parameter int DELAY_CYC = INIT_DELAY_CYC,
	parameter int SAMPLE_CYC = SAMPLE_MAX_CYC,
	parameter int SOFTSTART_CYC = SS_TIME_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	// analog comparators and gate feedback
	input wire logic supply_good,
	input wire logic pin_above_trip,
	input wire logic pwm_high,
	input wire logic high_side_sense,
	input wire logic switch_node_high,
	input wire logic low_side_sense,
	input wire logic overcurrent_cmp,
	input wire logic setpoint_reached,
	// drive and analog controls
	output logic high_side_gate,
	output logic low_side_gate,
	output logic osc_run,
	output logic error_amp_en,
	output logic pin_pullup_en,
	output logic setpoint_src_en,
	output logic [SP_W-1:0] setpoint_dac,
	output logic [SS_W-1:0] softstart_ref,
	output logic irq,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// derived step lengths; longest times round down, never below one cycle
	localparam int SP_STEP_RAW = SAMPLE_CYC / SP_STEPS;
	localparam int SS_STEP_RAW = SOFTSTART_CYC / SS_STEPS;
	localparam logic [TMR_W-1:0] DELAY_LAST = TMR_W'(DELAY_CYC - 1);
	localparam logic [TMR_W-1:0] SP_STEP_LAST = TMR_W'((SP_STEP_RAW < 1 ? 1 : SP_STEP_RAW) - 1);
	localparam logic [TMR_W-1:0] SS_STEP_LAST = TMR_W'((SS_STEP_RAW < 1 ? 1 : SS_STEP_RAW) - 1);
	localparam logic [TMR_W-1:0] SS_INIT_LAST = TMR_W'(SS_INIT_CYC - 1);
	localparam logic [2:0] BLANK = 3'(OC_BLANK_CYC);
	localparam logic [SS_W-1:0] SS_FULL = SS_W'(SS_STEPS);
	localparam logic [SP_W-1:0] SP_MAX = SP_W'(SP_STEPS - 1);
	localparam logic DUMMY_LAST = 1'(DUMMY_RUNS - 1);

	////////////////////////////////////////////////////////////////////////
	// pin input synchronisers: three flops, accept when second and third agree

	logic [N_IN-1:0] raw;
	logic [N_IN-1:0] s1_q;
	logic [N_IN-1:0] s2_q;
	logic [N_IN-1:0] s3_q;
	logic [N_IN-1:0] in_q;

	assign raw[IN_SUPPLY] = supply_good;
	assign raw[IN_PIN_UP] = pin_above_trip;
	assign raw[IN_PWM] = pwm_high;
	assign raw[IN_HS_SENSE] = high_side_sense;
	assign raw[IN_PHASE] = switch_node_high;
	assign raw[IN_LS_SENSE] = low_side_sense;
	assign raw[IN_OC] = overcurrent_cmp;
	assign raw[IN_SP_HIT] = setpoint_reached;

	// one filter per input; a single-cycle glitch never reaches in_q
	for (genvar i = 0; i < N_IN; i++) begin : g_sync
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				s1_q[i] <= 1'b0;
				s2_q[i] <= 1'b0;
				s3_q[i] <= 1'b0;
				in_q[i] <= 1'b0;
			end else begin
				s1_q[i] <= raw[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i]) begin
					in_q[i] <= s3_q[i];
				end
			end
		end
	end

	wire sup_ok = in_q[IN_SUPPLY];
	wire pin_up = in_q[IN_PIN_UP];

	////////////////////////////////////////////////////////////////////////
	// sequencer

	bss_state_t state_q, state_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [SP_W-1:0] sp_q, sp_d;
	logic [SS_W-1:0] lvl_q, lvl_d;
	logic dummy_q, dummy_d;
	logic oc_trip;
	logic ev_sampled;
	logic ev_ss_done;

	wire gates_allowed = (state_q == BSS_SOFTSTART) || (state_q == BSS_RUN);
	wire step_ss = (tmr_q >= SS_STEP_LAST);
	wire lvl_last = (lvl_q == SS_FULL - 7'h01);

	// next state; later checks override earlier ones in priority order
	always_comb begin
		state_d = state_q;
		tmr_d = TMR_W'(tmr_q + 24'h00_0001);
		sp_d = sp_q;
		lvl_d = lvl_q;
		dummy_d = dummy_q;
		ev_sampled = 1'b0;
		ev_ss_done = 1'b0;
		case (state_q)
			BSS_POR_WAIT: begin
				tmr_d = '0;
				state_d = BSS_DISABLED; // [R4] [R5] init started, timer waits for pin
			end
			BSS_DISABLED: begin
				tmr_d = '0; // [R6]
				if (pin_up) begin
					state_d = BSS_DELAY; // [R3] [R5]
					// drop the old setpoint now so the filtered compare settles before sampling
					sp_d = '0; // [R10]
				end
			end
			BSS_DELAY: begin
				if (tmr_q >= DELAY_LAST) begin
					state_d = BSS_SAMPLE; // [R7]
					tmr_d = '0;
					sp_d = '0;
				end
			end
			BSS_SAMPLE: begin
				if (in_q[IN_SP_HIT] || sp_q == SP_MAX) begin
					state_d = BSS_SS_INIT; // [R9] [R11]
					tmr_d = '0;
					ev_sampled = 1'b1;
				end else if (tmr_q >= SP_STEP_LAST) begin
					tmr_d = '0;
					sp_d = SP_W'(sp_q + 8'h01); // [R9] counter drives the dac
				end
			end
			BSS_SS_INIT: begin
				lvl_d = '0;
				if (tmr_q >= SS_INIT_LAST) begin
					state_d = BSS_SOFTSTART; // [R11]
					tmr_d = '0;
				end
			end
			BSS_SOFTSTART: begin
				if (step_ss) begin
					tmr_d = '0;
					lvl_d = SS_W'(lvl_q + 7'h01); // [R17]
					if (lvl_last) begin
						state_d = BSS_RUN;
						ev_ss_done = 1'b1;
					end
				end
			end
			BSS_RUN: begin
				tmr_d = '0;
			end
			BSS_HICCUP: begin
				// dummy run: same step timing, gates stay off, no new sample
				if (step_ss) begin
					tmr_d = '0;
					lvl_d = SS_W'(lvl_q + 7'h01);
					if (lvl_last) begin
						lvl_d = '0;
						dummy_d = ~dummy_q;
						if (dummy_q == DUMMY_LAST) begin
							state_d = BSS_SS_INIT; // [R13]
						end
					end
				end
			end
			default: begin
				state_d = BSS_POR_WAIT;
			end
		endcase
		if (oc_trip) begin
			state_d = BSS_HICCUP; // [R13]
			tmr_d = '0;
			lvl_d = '0;
			dummy_d = 1'b0;
		end
		if (!pin_up && state_q != BSS_POR_WAIT) begin
			state_d = BSS_DISABLED; // [R1] re-arm soft-start
			lvl_d = '0;
			dummy_d = 1'b0;
		end
		if (!sup_ok) begin
			state_d = BSS_POR_WAIT; // [R10] setpoint lost with supply
			tmr_d = '0;
			sp_d = '0;
			lvl_d = '0;
			dummy_d = 1'b0;
		end
	end

	// all sequencer state cleared by reset [R19]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= BSS_POR_WAIT;
			tmr_q <= '0;
			sp_q <= '0;
			lvl_q <= '0;
			dummy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			sp_q <= sp_d;
			lvl_q <= lvl_d;
			dummy_q <= dummy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gate interlock and overcurrent window

	logic hs_q;
	logic ls_q;
	logic [2:0] ls_on_cnt_q;
	logic [2:0] ls_on_cnt_d;

	// feedback is four cycles late, so the own drive is checked as well
	wire hs_d = gates_allowed && !oc_trip && in_q[IN_PWM] && !ls_q
		&& !in_q[IN_LS_SENSE]; // [R16]
	wire ls_d = gates_allowed && !oc_trip && !in_q[IN_PWM] && !hs_q
		&& !in_q[IN_HS_SENSE] && !in_q[IN_PHASE]; // [R15]
	assign ls_on_cnt_d = !ls_q ? 3'h0 : (ls_on_cnt_q < BLANK ? 3'(ls_on_cnt_q + 3'h1) : BLANK);
	// comparator already sees drop across the low side vs the dac [R14]
	wire oc_window = ls_q && (ls_on_cnt_q >= BLANK); // [R18]
	assign oc_trip = gates_allowed && oc_window && in_q[IN_OC]; // [R14]

	// analog control lines
	wire active_d = (state_d != BSS_POR_WAIT) && (state_d != BSS_DISABLED);
	wire amp_d = (state_d == BSS_SOFTSTART) || (state_d == BSS_RUN);
	wire src_d = (state_d == BSS_DELAY) || (state_d == BSS_SAMPLE); // [R8] [R12]
	wire [SS_W-1:0] ref_d = amp_d ? lvl_d : '0;

	logic osc_q;
	logic amp_q;
	logic pull_q;
	logic src_q;
	logic [SS_W-1:0] ref_q;

	// every drive output registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs_q <= 1'b0;
			ls_q <= 1'b0;
			ls_on_cnt_q <= 3'h0;
			osc_q <= 1'b0;
			amp_q <= 1'b0;
			pull_q <= 1'b1;
			src_q <= 1'b0;
			ref_q <= '0;
		end else begin
			hs_q <= hs_d && active_d; // [R1]
			ls_q <= ls_d && active_d; // [R1] [R8]
			ls_on_cnt_q <= ls_on_cnt_d;
			osc_q <= active_d; // [R1]
			amp_q <= amp_d; // [R2]
			pull_q <= !amp_d; // [R2]
			src_q <= src_d; // [R8]
			ref_q <= ref_d; // [R17]
		end
	end

	assign high_side_gate = hs_q;
	assign low_side_gate = ls_q;
	assign osc_run = osc_q;
	assign error_amp_en = amp_q;
	assign pin_pullup_en = pull_q;
	assign setpoint_src_en = src_q;
	assign setpoint_dac = sp_q;
	assign softstart_ref = ref_q;

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave: status, mask, state readback

	logic aw_rdy_q;
	logic w_rdy_q;
	logic aw_full_q;
	logic w_full_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic ar_rdy_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] mask_q;
	logic irq_q;

	wire aw_hs = s_axi_awvalid && aw_rdy_q;
	wire w_hs = s_axi_wvalid && w_rdy_q;
	wire b_hs = bvalid_q && s_axi_bready;
	wire ar_hs = s_axi_arvalid && ar_rdy_q;
	wire r_hs = rvalid_q && s_axi_rready;
	wire do_write = aw_full_q && w_full_q && !bvalid_q;

	// write decode
	wire wr_status = do_write && (waddr_q == REG_STATUS) && wstrb_q[0];
	wire wr_mask = do_write && (waddr_q == REG_MASK) && wstrb_q[0];
	wire wr_known = (waddr_q == REG_STATUS) || (waddr_q == REG_MASK) || (waddr_q == REG_STATE);

	// hardware events; set beats a same-cycle write-one clear
	wire [ST_W-1:0] ev_set = {
		(state_q != BSS_POR_WAIT) && (state_d == BSS_POR_WAIT),
		(state_q != BSS_DISABLED) && (state_d == BSS_DISABLED),
		ev_ss_done,
		ev_sampled,
		oc_trip
	};
	wire [ST_W-1:0] st_clr = wr_status ? wdata_q[ST_W-1:0] : '0;
	wire [ST_W-1:0] status_d = (status_q & ~st_clr) | ev_set;

	// read decode
	wire [31:0] state_word = (32'(state_q) << SR_STATE_LSB) | (32'(sp_q) << SR_SP_LSB)
		| (32'(lvl_q) << SR_SS_LSB);
	wire rd_status = (s_axi_araddr == REG_STATUS);
	wire rd_mask = (s_axi_araddr == REG_MASK);
	wire rd_state = (s_axi_araddr == REG_STATE);
	wire [31:0] rd_word = rd_status ? 32'(status_q) : rd_mask ? 32'(mask_q)
		: rd_state ? state_word : 32'h0000_0000;
	wire [1:0] rd_resp = (rd_status || rd_mask || rd_state) ? RESP_OKAY : RESP_SLVERR;

	// write channels: address and data taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_rdy_q <= 1'b1;
			w_rdy_q <= 1'b1;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_rdy_q <= 1'b0;
				aw_full_q <= 1'b1;
				waddr_q <= s_axi_awaddr;
			end else if (b_hs) begin
				aw_rdy_q <= 1'b1;
				aw_full_q <= 1'b0;
			end
			if (w_hs) begin
				w_rdy_q <= 1'b0;
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (b_hs) begin
				w_rdy_q <= 1'b1;
				w_full_q <= 1'b0;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (b_hs) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read channel: one cycle to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_rdy_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (ar_hs) begin
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_resp;
		end else if (r_hs) begin
			ar_rdy_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// sticky status, mask and the level interrupt
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= STATUS_RST;
			mask_q <= MASK_RST;
			irq_q <= 1'b0;
		end else begin
			status_q <= status_d;
			if (wr_mask) begin
				mask_q <= wdata_q[ST_W-1:0];
			end
			irq_q <= |(status_d & mask_q);
		end
	end

	assign irq = irq_q;
	assign s_axi_awready = aw_rdy_q;
	assign s_axi_wready = w_rdy_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ar_rdy_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule

`default_nettype wire

// File: core/bss_pkg.sv
// constants, register map and state type of the buck start-up sequencer
package bss_pkg;

	// time base
	localparam int CLK_PERIOD_NS = 100;

	// sequence times, figures in ns, counts derived from the clock period
	localparam int INIT_DELAY_NS = 6_800_000;
	localparam int INIT_DELAY_CYC = INIT_DELAY_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_MAX_NS = 3_400_000;
	localparam int SAMPLE_MAX_CYC = SAMPLE_MAX_NS / CLK_PERIOD_NS;
	localparam int SS_TIME_NS = 6_800_000;
	localparam int SS_TIME_CYC = SS_TIME_NS / CLK_PERIOD_NS;
	localparam int SS_INIT_NS = 10_000;
	localparam int SS_INIT_CYC = SS_INIT_NS / CLK_PERIOD_NS;
	localparam int OC_BLANK_NS = 200;
	localparam int OC_BLANK_CYC = (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// counter shapes
	localparam int SS_STEPS = 64;
	localparam int SS_W = 7;
	localparam int SP_W = 8;
	localparam int SP_STEPS = 256;
	localparam int TMR_W = 24;
	localparam int DUMMY_RUNS = 2;

	// register bus
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATE = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// status and mask layout
	localparam int ST_W = 5;
	localparam int ST_TRIP = 0;
	localparam int ST_SAMPLED = 1;
	localparam int ST_SS_DONE = 2;
	localparam int ST_DISABLED = 3;
	localparam int ST_SUPPLY_LOST = 4;
	localparam logic [ST_W-1:0] STATUS_RST = 5'h00;
	localparam logic [ST_W-1:0] MASK_RST = 5'h00;

	// state register layout
	localparam int SR_STATE_LSB = 0;
	localparam int SR_SP_LSB = 8;
	localparam int SR_SS_LSB = 16;

	// synchronised input indices
	localparam int N_IN = 8;
	localparam int IN_SUPPLY = 0;
	localparam int IN_PIN_UP = 1;
	localparam int IN_PWM = 2;
	localparam int IN_HS_SENSE = 3;
	localparam int IN_PHASE = 4;
	localparam int IN_LS_SENSE = 5;
	localparam int IN_OC = 6;
	localparam int IN_SP_HIT = 7;

	typedef enum logic [2:0] {
		BSS_POR_WAIT,
		BSS_DISABLED,
		BSS_DELAY,
		BSS_SAMPLE,
		BSS_SS_INIT,
		BSS_SOFTSTART,
		BSS_RUN,
		BSS_HICCUP
	} bss_state_t;

endpackage

// File: bench/bss_props.sv
// port-level checks of the buck start-up sequencer
`timescale 1ns/100ps
`default_nettype none

module bss_props
	import bss_pkg::*;
#(
	parameter int DELAY_CYC = INIT_DELAY_CYC,
	parameter int SAMPLE_CYC = SAMPLE_MAX_CYC,
	parameter int SOFTSTART_CYC = SS_TIME_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin_above_trip,
	input wire logic high_side_gate,
	input wire logic low_side_gate,
	input wire logic osc_run,
	input wire logic error_amp_en,
	input wire logic pin_pullup_en,
	input wire logic setpoint_src_en,
	input wire logic [SP_W-1:0] setpoint_dac,
	input wire logic [SS_W-1:0] softstart_ref
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	int src_cnt_q;

	// cycles the setpoint source has stood on; long delays are counted, not repeated
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_cnt_q <= 0;
		end else begin
			src_cnt_q <= setpoint_src_en ? src_cnt_q + 1 : 0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// gate interlock and shutdown
	chk_gates_exclusive: assert property (!(high_side_gate && low_side_gate))
		else $error("both gates driven");
	chk_disable_off: assert property (!pin_above_trip [*8]
		|-> !high_side_gate && !low_side_gate && !osc_run)
		else $error("gates or oscillator on while pin held low");
	chk_pullup_amp: assert property (pin_pullup_en == !error_amp_en)
		else $error("pull-up and error amp out of step");
	chk_gates_amp: assert property (high_side_gate || low_side_gate
		|-> error_amp_en && osc_run)
		else $error("switching before soft-start");

	////////////////////////////////////////////////////////////////////////////////
	// setpoint sampling and soft-start ramp
	chk_src_gate_off: assert property (setpoint_src_en |-> !low_side_gate && !error_amp_en)
		else $error("low side driven while sensing setpoint");
	chk_delay_min: assert property ($rose(setpoint_src_en)
		|-> (setpoint_src_en && setpoint_dac == 8'h00) [*8])
		else $error("sampling started without delay");
	chk_delay_len: assert property ($changed(setpoint_dac) && $past(setpoint_dac) == 8'h00
		&& setpoint_src_en |-> src_cnt_q >= DELAY_CYC)
		else $error("first setpoint step before the delay ran out");
	chk_sample_len: assert property (src_cnt_q <= DELAY_CYC + SAMPLE_CYC + SP_STEPS + 8)
		else $error("setpoint sampling ran past its maximum");
	chk_dac_held: assert property ($changed(setpoint_dac) && setpoint_dac != 8'h00
		|-> $past(setpoint_src_en))
		else $error("setpoint moved outside sampling");
	chk_ref_steps: assert property ($changed(softstart_ref) && softstart_ref != 7'h00
		|-> softstart_ref == $past(softstart_ref) + 7'h01 && softstart_ref <= 7'h40)
		else $error("soft-start reference skipped a step");
endmodule

bind bss_top bss_props #(
	.DELAY_CYC(DELAY_CYC),
	.SAMPLE_CYC(SAMPLE_CYC),
	.SOFTSTART_CYC(SOFTSTART_CYC)
) i_bss_props (.aclk, .aresetn, .pin_above_trip, .high_side_gate, .low_side_gate, .osc_run,
	.error_amp_en, .pin_pullup_en, .setpoint_src_en, .setpoint_dac, .softstart_ref);

`default_nettype wire

// File: bench/bss_bridge.sv
// half-bridge, setpoint resistor and disable pull-down model
`timescale 1ns/100ps
`default_nettype none

module bss_bridge
	import bss_pkg::*;
#(
	parameter int LAG = 2,
	parameter int RISE = 12
) (
	input wire logic aclk,
	input wire logic high_side_gate,
	input wire logic low_side_gate,
	input wire logic [SP_W-1:0] setpoint_dac,
	input wire logic pull_low,
	input wire logic short_out,
	input wire logic [SP_W-1:0] sp_level,
	output logic pin_above_trip,
	output logic high_side_sense,
	output logic switch_node_high,
	output logic low_side_sense,
	output logic overcurrent_cmp,
	output logic setpoint_reached
);
	logic [7:0] hs_q = 8'h00;
	logic [7:0] ls_q = 8'h00;
	int rise_q = 0;

	// gates discharge slowly, pin charges slowly after the pull-down lets go
	always_ff @(posedge aclk) begin
		hs_q <= {hs_q[6:0], high_side_gate};
		ls_q <= {ls_q[6:0], low_side_gate};
		rise_q <= pull_low ? 0 : (rise_q < RISE ? rise_q + 1 : rise_q);
	end

	// transistor still on until its gate charge is gone
	assign high_side_sense = high_side_gate || (|hs_q[LAG-1:0]);
	assign switch_node_high = high_side_sense;
	assign low_side_sense = low_side_gate || (|ls_q[LAG-1:0]);
	assign overcurrent_cmp = short_out && low_side_sense;
	assign setpoint_reached = setpoint_dac >= sp_level;
	assign pin_above_trip = rise_q >= RISE;
endmodule

`default_nettype wire

// File: bench/test_buck_init_shutdown_sequencer.sv
// self-checking bench of the buck start-up sequencer
`timescale 1ns/100ps
`default_nettype none

module test_buck_init_shutdown_sequencer;
	import bss_pkg::*;
	localparam int DLY = 40;
	localparam int SMP = 2048;
	localparam int SST = 256;
	logic aclk = 0, aresetn = 0, supply_good = 0, pwm_high = 0, pwm_on = 0;
	logic pull_low = 1, short_out = 0, irq, osc_run, error_amp_en, pin_pullup_en;
	logic pin_above_trip, high_side_sense, switch_node_high, low_side_sense, overcurrent_cmp;
	logic setpoint_reached, high_side_gate, low_side_gate, setpoint_src_en;
	logic [SP_W-1:0] setpoint_dac, lvl = 8'h01;
	logic [SS_W-1:0] softstart_ref;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_v, seed = 32'h0000_e6f5;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	int n_mismatch = 0, checked = 0, n;

	bss_top #(.DELAY_CYC(DLY), .SAMPLE_CYC(SMP), .SOFTSTART_CYC(SST)) i_bss_top (
		.aclk, .aresetn, .supply_good, .pin_above_trip, .pwm_high, .high_side_sense,
		.switch_node_high, .low_side_sense, .overcurrent_cmp, .setpoint_reached,
		.high_side_gate, .low_side_gate, .osc_run, .error_amp_en, .pin_pullup_en,
		.setpoint_src_en, .setpoint_dac, .softstart_ref, .irq, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	bss_bridge i_bss_bridge (.aclk, .high_side_gate, .low_side_gate, .setpoint_dac, .pull_low,
		.short_out, .sp_level(lvl), .pin_above_trip, .high_side_sense, .switch_node_high,
		.low_side_sense, .overcurrent_cmp, .setpoint_reached);

	////////////////////////////////////////////////////////////////////////////////
	// clock, random source and pwm stimulus
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	always #50 aclk = ~aclk;

	// one draw per cycle keeps the sequence repeatable
	always @(posedge aclk) begin
		seed <= xs(seed);
		pwm_high <= pwm_on & seed[3];
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, verdict and bus tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task test_done;
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task to(input int lim);
		if (n >= lim) begin
			n_mismatch++;
			test_done;
		end
	endtask

	// address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
		resp = s_axi_bresp;
		to(50);
	endtask

	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		s_axi_rready <= 0;
		rd_v = s_axi_rdata;
		resp = s_axi_rresp;
		to(50);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		supply_good <= 1;
		repeat (20) @(posedge aclk);
		rd(REG_STATE);
		chk(rd_v[2:0], 3'h1);
		chk(setpoint_src_en, 1'b0);
		wr(REG_MASK, 32'h0000_0004);
		chk(irq, 1'b0);
		// a write with no byte lane enabled must leave the mask alone
		s_axi_wstrb <= 4'h0;
		wr(REG_MASK, 32'h0000_001f);
		s_axi_wstrb <= 4'hf;
		rd(REG_MASK);
		chk(rd_v, 32'h0000_0004);
		rd(8'h0c);
		chk(rd_v, 32'h0000_0000);
		chk(resp, RESP_SLVERR);
		wr(8'h10, 32'h0000_001f);
		chk(resp, RESP_SLVERR);
		for (int k = 0; k < 2; k++) begin
			lvl <= 8'h01 + 8'(seed % 200);
			pull_low <= 0;
			for (n = 0; n < 500 && !setpoint_src_en; n++) @(posedge aclk);
			to(500);
			for (n = 0; n < 500 && setpoint_dac === 8'h00; n++) @(posedge aclk);
			chk(n >= DLY - 2 && n <= DLY + SMP / 256 + 4, 1);
			for (n = 0; n < 9000 && softstart_ref !== 7'h40; n++) @(posedge aclk);
			to(9000);
			chk(setpoint_dac, lvl);
			chk({error_amp_en, pin_pullup_en, setpoint_src_en}, 3'h4);
			rd(REG_STATUS);
			chk(rd_v, 32'h0000_000e);
			chk(irq, 1'b1);
			wr(REG_STATUS, 32'h0000_001f);
			rd(REG_STATUS);
			chk(rd_v, 32'h0000_0000);
			chk(irq, 1'b0);
			wr(REG_STATE, 32'hffff_ffff);
			chk(resp, RESP_OKAY);
			rd(REG_STATE);
			chk(rd_v, {9'h000, 7'h40, lvl, 5'h00, 3'h6});
			pwm_on <= 1;
			repeat (200) @(posedge aclk);
			if (k == 0) begin
				pull_low <= 1;
				repeat (10) @(posedge aclk);
				chk({high_side_gate, low_side_gate, osc_run, error_amp_en}, 4'h0);
				rd(REG_STATE);
				chk(rd_v[2:0], 3'h1);
			end
		end
		// short on the output while the low side conducts
		pwm_on <= 0;
		short_out <= 1;
		for (n = 0; n < 100 && softstart_ref !== 7'h00; n++) @(posedge aclk);
		to(100);
		short_out <= 0;
		rd(REG_STATE);
		chk(rd_v[2:0], 3'h7);
		for (n = 0; n < 3000 && softstart_ref !== 7'h40; n++) @(posedge aclk);
		to(3000);
		chk(n >= 3 * SST - 20, 1);
		chk(setpoint_dac, lvl);
		rd(REG_STATUS);
		chk(rd_v[0], 1'b1);
		supply_good <= 0;
		repeat (10) @(posedge aclk);
		chk({setpoint_dac, error_amp_en, low_side_gate}, 10'h0);
		rd(REG_STATUS);
		chk(rd_v[4], 1'b1);
		test_done;
	end
endmodule

`default_nettype wire
